// ### logic/prx_params.svh
// constants, offsets and timing counts of the receive, status and strap pin block
//
// Functional notes
// - raise receive error whenever an error appears inside the frame being passed.
// - with energy saving on, error output is error while valid, idle indication otherwise.
// - in reduced mode the error output is optional; nothing depends on it.
// - in symbol mode drive rx_symbol_msb with the top bit of each code-group; the code does so in MII mode only, RMII keeps receive error.
// - outside symbol mode the rx_symbol_msb pin carries receive error.
// - in MII mode receive clock is 25 MHz at 100 Mbps, 2.5 MHz at 10.
// - receive valid is high only while decoded data sits on the data outputs.
// - in MII mode raise collision whenever the medium shows a collision.
// - in MII mode raise carrier sense whenever a carrier is seen.
// - in RMII mode raise carrier/valid whenever the medium is not idle.
// - RMII at 10 Mbps: carrier/valid at once, data low until the 10101011 delimiter.
// - RMII 10 Mbps half duplex never loops transmit data to the receive outputs.
// - capture all straps at every reset and use them as defaults.
// - three address straps form the management address.
// - three operating mode straps choose the default mode after reset.
// - link indicator active with link, blinking on traffic.
// - speed indicator active at 100 Mbps, inactive at 10 or when isolated.
// - pin-function strap high gives interrupt output, low gives transmit error input.
// - regulator disable strap high turns the internal regulator off.
// - reduced interface strap low selects MII, high selects RMII.
// - RMII uses two receive data bits, MII four.
`ifndef PRX_PARAMS_SVH
`define PRX_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PRX_CLK_NS      10
`define PRX_RXCLK100_NS 40
`define PRX_RXCLK10_NS  400
`define PRX_HALF100     (`PRX_RXCLK100_NS / 2 / `PRX_CLK_NS)
`define PRX_HALF10      (`PRX_RXCLK10_NS / 2 / `PRX_CLK_NS)
`define PRX_STRAP_NS    100
`define PRX_STRAP_CYC   ((`PRX_STRAP_NS + `PRX_CLK_NS - 1) / `PRX_CLK_NS)
`define PRX_BLINK_MS    50
`define PRX_BLINK_CYC   (`PRX_BLINK_MS * 1000000 / `PRX_CLK_NS)

// ----------------------------------------------------------------
// register map, field layout and reset values
// ----------------------------------------------------------------
`define PRX_OFF_CTRL    8'h00
`define PRX_OFF_STATUS  8'h04
`define PRX_OFF_ERRCNT  8'h08
`define PRX_CTRL_W      6
`define PRX_STRAP_W     9
`define PRX_STAT_LINK   10
`define PRX_CTRL_RST    6'h00
`define PRX_ERRCNT_RST  16'h0000
`define PRX_SFD         8'hAB

`endif

// ### logic/prx_pkg.sv
// types of the receive, status and strap pin block
package prx_pkg;

  typedef enum logic [1:0] {
    PRX_ST_RESET  = 2'b00,
    PRX_ST_SAMPLE = 2'b01,
    PRX_ST_RUN    = 2'b11
  } prx_state_e;

  // strap pins, also the latched strap set
  typedef struct packed {
    logic addr_strap_bit2;
    logic addr_strap_bit1;
    logic addr_strap_bit0;
    logic opsel_strap_bit2;
    logic opsel_strap_bit1;
    logic opsel_strap_bit0;
    logic reduced_interface_strap;
    logic regulator_disable_strap;
    logic irq_pin_function_strap;
  } prx_strap_s;

  // receive side of the line core
  typedef struct packed {
    logic       clk;
    logic       link;
    logic       crs;
    logic       col;
    logic       dv;
    logic       err;
    logic       lpi;
    logic [4:0] data;
  } prx_line_s;

  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } prx_tx_s;

  // MAC facing and indicator pins
  typedef struct packed {
    logic       rxclk;
    logic [3:0] rxd;
    logic       rx_symbol_msb;
    logic       rxdv;
    logic       crs;
    logic       col_crs_dv;
    logic       link_activity_indicator;
    logic       speed_indicator;
  } prx_pins_s;

  typedef struct packed {
    logic loopback;
    logic isolate;
    logic symbol_en;
    logic eee_en;
    logic full_duplex;
    logic speed100;
  } prx_ctrl_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } prx_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } prx_apb_rsp_s;

  typedef struct packed {
    prx_state_e  st;
    logic [3:0]  win;
    prx_strap_s  strap;
    prx_ctrl_s   ctrl;
    prx_line_s   ln1;
    prx_line_s   ln2;
    logic        lclk;
    prx_strap_s  sp1;
    prx_strap_s  sp2;
    prx_tx_s     tx1;
    prx_tx_s     tx2;
    logic        p1;
    logic        p2;
    prx_pins_s   pins;
    logic [7:0]  sfd_sr;
    logic        sfd_seen;
    logic        frm_err;
    logic [15:0] errcnt;
    logic [4:0]  div;
    logic [22:0] act_tmr;
    logic [31:0] prdata;
  } prx_state_s;

endpackage : prx_pkg

// ### logic/prx_rx_status.sv
// receive pin, status indicator and strap capture logic with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "prx_params.svh"

module prx_rx_status #(
  parameter int unsigned BLINK_CYCLES = `PRX_BLINK_CYC
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // register bus
  input  wire prx_pkg::prx_apb_req_s apb_req,
  output var  prx_pkg::prx_apb_rsp_s apb_rsp,
  // line core receive side, asynchronous
  input  wire prx_pkg::prx_line_s    line_i,
  // MAC transmit pins, asynchronous
  input  wire prx_pkg::prx_tx_s      tx_i,
  // shared output pins with straps
  input  wire prx_pkg::prx_strap_s   strap_pin_i,
  output var  prx_pkg::prx_pins_s    pin_o,
  output logic                       pin_oe,
  // interrupt or transmit error pin
  input  wire logic                  irq_req,
  input  wire logic                  irq_pin_i,
  output logic                       irq_out_n,
  output logic                       irq_pin_oe,
  output logic                       tx_err_o,
  // latched configuration
  output logic [2:0]                 mgmt_addr,
  output logic [2:0]                 op_mode,
  output logic                       rmii_mode,
  output logic                       regulator_disable,
  output logic                       straps_done
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL   = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_ERRCNT = 2'h2;
  localparam logic [1:0] SEL_NONE   = 2'h3;

  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    logic [1:0] s;
    s = SEL_NONE;
    if (a == `PRX_OFF_CTRL)
    begin
      s = SEL_CTRL;
    end
    else if (a == `PRX_OFF_STATUS)
    begin
      s = SEL_STATUS;
    end
    else if (a == `PRX_OFF_ERRCNT)
    begin
      s = SEL_ERRCNT;
    end
    return s;
  endfunction : reg_sel

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  prx_pkg::prx_state_s q;
  prx_pkg::prx_state_s d;

  logic        run;
  logic        edge_l;
  logic        rmii;
  logic        rmii10;
  logic        lb;
  logic        src_dv;
  logic        src_err;
  logic        src_lpi;
  logic        src_crs;
  logic        src_col;
  logic [4:0]  src_data;
  logic        rx_err;
  logic [7:0]  sr_nxt;
  logic [4:0]  half;
  logic        activity;
  logic        blink_off;
  logic        setup;
  logic        wr;
  logic [1:0]  sel;

  assign run  = (q.st == prx_pkg::PRX_ST_RUN);
  assign rmii = q.strap.reduced_interface_strap;
  assign rmii10 = rmii & ~q.ctrl.speed100;
  // loopback is blocked for reduced mode at 10 Mbps half duplex
  assign lb = q.ctrl.loopback & ~(rmii10 & ~q.ctrl.full_duplex);
  assign edge_l = q.ln2.clk & ~q.lclk;

  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr    = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign sel   = reg_sel(apb_req.paddr);

  // ----------------------------------------------------------------
  // receive source selection
  // ----------------------------------------------------------------
  always_comb
  begin
    if (lb)
    begin
      src_dv   = q.tx2.en;
      src_data = {1'b0, q.tx2.d};
      src_err  = 1'b0;
      src_lpi  = 1'b0;
      src_crs  = q.tx2.en;
      src_col  = 1'b0;
    end
    else
    begin
      src_dv   = q.ln2.dv;
      src_data = q.ln2.data;
      src_err  = q.ln2.err;
      src_lpi  = q.ln2.lpi;
      src_crs  = q.ln2.crs;
      src_col  = q.ln2.col;
    end
    // error only counts inside a frame; idle indication shares the pin
    if (q.ctrl.eee_en)
    begin
      rx_err = src_dv ? src_err : src_lpi;
    end
    else
    begin
      rx_err = src_dv & src_err;
    end
  end

  assign sr_nxt   = {src_data[1:0], q.sfd_sr[7:2]};
  assign half     = q.ctrl.speed100 ? 5'(`PRX_HALF100) : 5'(`PRX_HALF10);
  assign activity = src_dv | q.tx2.en;
  // second half of each blink window darkens the link indicator
  assign blink_off = (q.act_tmr != 23'h000000) &&
                     (q.act_tmr < 23'(BLINK_CYCLES / 2));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;

    // two-stage synchronisers on the asynchronous inputs: line, transmit, strap and pin
    d.ln1  = line_i;
    d.ln2  = q.ln1;
    d.sp1  = strap_pin_i;
    d.sp2  = q.sp1;
    d.tx1  = tx_i;
    d.tx2  = q.tx1;
    d.p1   = irq_pin_i;
    d.p2   = q.p1;
    d.lclk = q.ln2.clk;

    // strap window: pins undriven, levels settle through the synchroniser
    unique case (q.st)
      prx_pkg::PRX_ST_RESET:
      begin
        d.st  = prx_pkg::PRX_ST_SAMPLE;
        d.win = 4'h0;
      end
      prx_pkg::PRX_ST_SAMPLE:
      begin
        if (q.win == 4'(`PRX_STRAP_CYC - 1))
        begin
          d.st    = prx_pkg::PRX_ST_RUN;
          d.strap = q.sp2;
          // mode straps: bit1 picks speed, bit0 picks duplex
          d.ctrl.speed100    = q.sp2.opsel_strap_bit1;
          d.ctrl.full_duplex = q.sp2.opsel_strap_bit0;
        end
        else
        begin
          d.win = q.win + 4'h1;
        end
      end
      prx_pkg::PRX_ST_RUN:
      begin
        d.st = prx_pkg::PRX_ST_RUN;
      end
      default:
      begin
        d.st = prx_pkg::PRX_ST_RESET;
      end
    endcase

    // control register writes only once straps are in; error count clears at any time
    if (wr && run && sel == SEL_CTRL)
    begin
      d.ctrl = prx_pkg::prx_ctrl_s'(apb_req.pwdata[`PRX_CTRL_W-1:0]);
    end
    if (wr && sel == SEL_ERRCNT)
    begin
      d.errcnt = `PRX_ERRCNT_RST;
    end

    // read data is prepared in the setup phase
    if (setup)
    begin
      unique case (sel)
        SEL_CTRL:
        begin
          d.prdata = {26'h0000000, q.ctrl};
        end
        SEL_STATUS:
        begin
          d.prdata = {19'h00000, q.ln2.col, q.ln2.crs, q.ln2.link, run,
                      q.strap};
        end
        SEL_ERRCNT:
        begin
          d.prdata = {16'h0000, q.errcnt};
        end
        SEL_NONE:
        begin
          d.prdata = 32'h00000000;
        end
      endcase
    end

    // receive clock divider, held low in RMII mode
    if (rmii)
    begin
      d.div        = 5'h00;
      d.pins.rxclk = 1'b0;
    end
    else if (q.div >= half - 5'h01)
    begin
      d.div        = 5'h00;
      d.pins.rxclk = ~q.pins.rxclk;
    end
    else
    begin
      d.div = q.div + 5'h01;
    end

    // one symbol per line clock edge
    if (edge_l && run)
    begin
      if (rmii10 && !src_crs)
      begin
        d.sfd_sr   = 8'h00;
        d.sfd_seen = 1'b0;
      end
      else if (rmii10)
      begin
        d.sfd_sr = sr_nxt;
        if (sr_nxt == `PRX_SFD)
        begin
          d.sfd_seen = 1'b1;
        end
      end

      if (rmii)
      begin
        // two data bits; zero until the delimiter at 10 Mbps
        d.pins.rxd = {2'b00, (rmii10 && !q.sfd_seen) ? 2'b00
                                                     : src_data[1:0]};
        d.pins.col_crs_dv = src_crs;
      end
      else
      begin
        d.pins.rxd        = src_data[3:0];
        d.pins.col_crs_dv = src_col;
      end
      d.pins.rxdv = src_dv;
      d.pins.crs  = src_crs;
      // nothing below reads the error pin back, so leaving it open is safe
      if (q.ctrl.symbol_en && !rmii)
      begin
        d.pins.rx_symbol_msb = src_data[4];
      end
      else
      begin
        d.pins.rx_symbol_msb = rx_err;
      end

      // errored frame counter; the increment beats a same-cycle clear
      if (src_dv && src_err)
      begin
        d.frm_err = 1'b1;
      end
      if (q.pins.rxdv && !src_dv)
      begin
        d.frm_err = 1'b0;
        if (q.frm_err)
        begin
          d.errcnt = q.errcnt + 16'h0001;
        end
      end
    end

    // activity blink window
    if (q.act_tmr != 23'h000000)
    begin
      d.act_tmr = q.act_tmr - 23'h000001;
    end
    else if (activity && q.ln2.link)
    begin
      d.act_tmr = 23'(BLINK_CYCLES - 1);
    end
    d.pins.link_activity_indicator = q.ln2.link & ~blink_off;
    d.pins.speed_indicator = q.ctrl.speed100 & ~q.ctrl.isolate;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      q        <= '0;
      q.st     <= prx_pkg::PRX_ST_RESET;
      q.ctrl   <= `PRX_CTRL_RST;
      q.errcnt <= `PRX_ERRCNT_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & (sel == SEL_NONE);

  assign pin_o  = q.pins;
  assign pin_oe = run;

  // open-drain interrupt only while the strap picks that function
  assign irq_out_n  = 1'b0;
  assign irq_pin_oe = run & q.strap.irq_pin_function_strap & irq_req;
  assign tx_err_o   = run & ~q.strap.irq_pin_function_strap & q.p2;

  assign mgmt_addr = {q.strap.addr_strap_bit2, q.strap.addr_strap_bit1,
                      q.strap.addr_strap_bit0};
  assign op_mode   = {q.strap.opsel_strap_bit2, q.strap.opsel_strap_bit1,
                      q.strap.opsel_strap_bit0};
  assign rmii_mode         = rmii;
  assign regulator_disable = q.strap.regulator_disable_strap;
  assign straps_done       = run;

endmodule : prx_rx_status

`default_nettype wire

// ### tb/prx_rx_status_properties.sv
// assertions on the pins and latched straps of the receive and status block
`timescale 1ns/1ps
`default_nettype none

module prx_rx_status_properties (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  // straps and pins
  input wire prx_pkg::prx_strap_s strap_pin_i,
  input wire prx_pkg::prx_pins_s  pin_o,
  input wire logic                pin_oe,
  // interrupt or transmit error pin
  input wire logic                irq_out_n,
  input wire logic                irq_pin_oe,
  input wire logic                tx_err_o,
  // latched configuration
  input wire logic [2:0]          mgmt_addr,
  input wire logic [2:0]          op_mode,
  input wire logic                rmii_mode,
  input wire logic                regulator_disable,
  input wire logic                straps_done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  a_release_quiet: assert property ($fell(sys_rst) |-> !pin_oe && !straps_done)
    else $error("pins driven or straps taken at reset release");
  a_capture_time: assert property ($fell(sys_rst) |-> ##[8:14] straps_done)
    else $error("straps not captured in time");
  a_window_undriven: assert property (!straps_done |-> !pin_oe)
    else $error("shared pins driven during strap window");
  a_capture_addr: assert property ($rose(straps_done) |->
    mgmt_addr == strap_pin_i[8:6] && op_mode == strap_pin_i[5:3])
    else $error("address or mode strap latched wrong");
  a_capture_cfg: assert property ($rose(straps_done) |->
    rmii_mode == strap_pin_i[2] && regulator_disable == strap_pin_i[1])
    else $error("interface or regulator strap latched wrong");
  a_straps_held: assert property (straps_done && $past(straps_done) |->
    $stable({mgmt_addr, op_mode, rmii_mode, regulator_disable}))
    else $error("latched straps moved");

  // ------------------------------------------------------------
  // pin functions
  // ------------------------------------------------------------
  a_irq_exclusive: assert property (irq_pin_oe |-> !irq_out_n && !tx_err_o)
    else $error("interrupt and transmit error both active");
  a_rmii_no_clock: assert property (straps_done && rmii_mode |->
    !pin_o.rxclk && pin_o.rxd[3:2] == 2'h0)
    else $error("receive clock or upper data active in reduced mode");
  a_mii_clock_min: assert property (straps_done && !rmii_mode && $changed(pin_o.rxclk)
    |=> $stable(pin_o.rxclk))
    else $error("receive clock faster than 25 MHz");
  a_crs_dv_rmii: assert property (rmii_mode && pin_o.rxdv |-> pin_o.col_crs_dv)
    else $error("valid data without carrier in reduced mode");

  c_capture: cover property ($rose(straps_done));
  c_rmii_frame: cover property (rmii_mode && pin_o.col_crs_dv);
  c_irq: cover property (irq_pin_oe);
endmodule : prx_rx_status_properties

`default_nettype wire

// ### tb/prx_line_model.sv
// line core and MAC side model around the receive pins
`timescale 1ns/1ps
`default_nettype none

module prx_line_model (
  // clock
  input  wire logic               clk_sys,
  // line side
  output var  prx_pkg::prx_line_s line_o,
  // MAC side; receive error is left unwatched on purpose
  input  wire prx_pkg::prx_pins_s pin_i,
  output var  prx_pkg::prx_tx_s   tx_o
);
  initial
  begin
    line_o = '0;
    tx_o   = '0;
  end

  // one symbol, 90 ns line clock; the clock stands still between calls
  task automatic put(input logic [4:0] d, input logic dv, input logic crs, input logic err);
    line_o.data <= d;
    line_o.dv   <= dv;
    line_o.crs  <= crs;
    line_o.err  <= err;
    @(posedge clk_sys);
    line_o.clk <= 1'b1;
    repeat (4) @(posedge clk_sys);
    line_o.clk <= 1'b0;
    if (!dv)
      line_o.data <= ~d;
    repeat (4) @(posedge clk_sys);
  endtask : put

  task automatic flags(input logic link, input logic col, input logic lpi);
    line_o.link <= link;
    line_o.col  <= col;
    line_o.lpi  <= lpi;
    repeat (6) @(posedge clk_sys);
  endtask : flags

  task automatic tx(input logic en, input logic [3:0] d);
    tx_o <= '{en: en, d: d};
    @(posedge clk_sys);
  endtask : tx
endmodule : prx_line_model

`default_nettype wire

// ### tb/prx_rx_status_test.sv
// self-checking bench of the receive, status and strap pin block
`timescale 1ns/1ps
`default_nettype none
`include "prx_params.svh"

module prx_rx_status_test;
  logic                  clk_sys, sys_rst, pin_oe, irq_req, irq_drv, irq_wire;
  logic                  irq_out_n, irq_pin_oe, tx_err, rmii_mode, reg_dis, straps_done;
  logic [2:0]            mgmt_addr, op_mode;
  prx_pkg::prx_apb_req_s apb_req;
  prx_pkg::prx_apb_rsp_s apb_rsp;
  prx_pkg::prx_line_s    line;
  prx_pkg::prx_tx_s      tx;
  prx_pkg::prx_strap_s   strap;
  prx_pkg::prx_pins_s    pin;
  logic [31:0]           rd;
  logic                  err;
  int                    n_fail, checks;

  // open-drain pin with pull-up
  assign irq_wire = irq_pin_oe ? irq_out_n : irq_drv;

  prx_rx_status #(.BLINK_CYCLES(20)) prx_rx_status_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .line_i(line), .tx_i(tx), .strap_pin_i(strap), .pin_o(pin), .pin_oe(pin_oe),
    .irq_req(irq_req), .irq_pin_i(irq_wire), .irq_out_n(irq_out_n),
    .irq_pin_oe(irq_pin_oe), .tx_err_o(tx_err), .mgmt_addr(mgmt_addr), .op_mode(op_mode),
    .rmii_mode(rmii_mode), .regulator_disable(reg_dis), .straps_done(straps_done));

  prx_line_model prx_line_model_i (.clk_sys(clk_sys), .line_o(line), .pin_i(pin), .tx_o(tx));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 20);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n == 20)
    begin
      n_fail++;
      $display("Error at %0t: no ready from register bus", $time);
    end
    // one idle edge so a following call never re-raises psel in the same step
    @(posedge clk_sys);
  endtask : apb

  task automatic sym(input logic [4:0] d, input logic dv, input logic crs, input logic er,
                     input logic [3:0] xd, input logic xm, input logic xc);
    prx_line_model_i.put(d, dv, crs, er);
    if (dv)
      chk(pin.rxd, xd);
    chk(pin.rx_symbol_msb, xm);
    chk(pin.col_crs_dv, xc);
    if (!rmii_mode)
    begin
      chk(pin.rxdv, dv);
      chk(pin.crs, crs);
    end
  endtask : sym

  // edges between two receive clock toggles
  task automatic half(input int exp);
    logic v;
    int   n;
    for (int k = 0; k < 2; k++)
    begin
      v = pin.rxclk;
      n = 0;
      while (pin.rxclk === v && n < 50)
      begin
        @(posedge clk_sys);
        n++;
      end
    end
    chk(n, exp);
  endtask : half

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_straps(input prx_pkg::prx_strap_s s);
    strap <= s;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk({pin_oe, straps_done}, 2'h0);
    repeat (9) @(posedge clk_sys);
    chk(straps_done, 1'b1);
    chk(pin_oe, 1'b1);
    chk(mgmt_addr, s[8:6]);
    chk(op_mode, s[5:3]);
    chk(rmii_mode, s[2]);
    chk(reg_dis, s[1]);
    apb(1'b0, `PRX_OFF_STATUS, 32'h0);
    chk(rd[9:0], {1'b1, s});
    strap <= ~s;
    repeat (10) @(posedge clk_sys);
    chk({mgmt_addr, op_mode, rmii_mode, reg_dis}, {s[8:3], s[2:1]});
    $display("test straps done");
  endtask : t_straps

  task automatic t_irq(input logic fn);
    irq_req <= 1'b1;
    irq_drv <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({irq_pin_oe, irq_out_n}, {fn, 1'b0});
    chk(tx_err, !fn);
    irq_req <= 1'b0;
    irq_drv <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk({irq_pin_oe, tx_err}, 2'h0);
    irq_drv <= 1'b1;
    $display("test pin function done");
  endtask : t_irq

  task automatic t_ctrl();
    apb(1'b0, `PRX_OFF_CTRL, 32'h0);
    chk(rd, 32'h3);
    chk(pin.speed_indicator, 1'b1);
    half(2);
    apb(1'b1, `PRX_OFF_CTRL, 32'h13);
    repeat (4) @(posedge clk_sys);
    chk(pin.speed_indicator, 1'b0);
    apb(1'b1, `PRX_OFF_CTRL, 32'h2);
    half(20);
    chk(pin.speed_indicator, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, `PRX_OFF_CTRL, 32'h3);
    $display("test control done");
  endtask : t_ctrl

  task automatic t_mii();
    logic [15:0] nib;
    nib = 16'h3F5A;
    prx_line_model_i.flags(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
      sym({1'b0, nib[4*i+:4]}, 1, 1, 0, nib[4*i+:4], 0, 0);
    sym(5'h13, 1, 1, 1, 4'h3, 1, 0);
    sym(5'h13, 1, 1, 0, 4'h3, 0, 0);
    apb(1'b1, `PRX_OFF_CTRL, 32'hB);
    sym(5'h14, 1, 1, 0, 4'h4, 1, 0);
    sym(5'h0F, 1, 1, 1, 4'hF, 0, 0);
    apb(1'b1, `PRX_OFF_CTRL, 32'h7);
    prx_line_model_i.flags(1'b1, 1'b0, 1'b1);
    sym(5'h02, 0, 1, 0, 4'h2, 1, 0);
    sym(5'h02, 1, 1, 0, 4'h2, 0, 0);
    prx_line_model_i.flags(1'b1, 1'b1, 1'b0);
    sym(5'h05, 1, 1, 0, 4'h5, 0, 1);
    prx_line_model_i.flags(1'b1, 1'b0, 1'b0);
    sym(5'h05, 0, 0, 0, 4'h0, 0, 0);
    // one frame carried an error while valid
    apb(1'b0, `PRX_OFF_ERRCNT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `PRX_OFF_ERRCNT, 32'h0);
    apb(1'b0, `PRX_OFF_ERRCNT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `PRX_OFF_CTRL, 32'h3);
    $display("test receive done");
  endtask : t_mii

  task automatic t_led();
    int n;
    n = 0;
    repeat (40) @(posedge clk_sys);
    chk(pin.link_activity_indicator, 1'b1);
    fork
      // a short frame, then idle so the blink window can run out
      begin
        prx_line_model_i.put(5'h01, 1'b1, 1'b1, 1'b0);
        prx_line_model_i.put(5'h01, 1'b0, 1'b0, 1'b0);
      end
      repeat (60)
      begin
        @(posedge clk_sys);
        n += int'(pin.link_activity_indicator === 1'b0);
      end
    join
    chk(n != 0, 1'b1);
    chk(pin.link_activity_indicator, 1'b1);
    prx_line_model_i.flags(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk(pin.link_activity_indicator, 1'b0);
    $display("test indicator done");
  endtask : t_led

  task automatic t_rmii();
    logic [27:0] dib;
    dib = 28'h6AB5555;
    apb(1'b0, `PRX_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    prx_line_model_i.flags(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 14; i++)
      sym({3'h0, dib[2*i+:2]}, 1, 1, 0, (i < 12) ? 4'h0 : {2'h0, dib[2*i+:2]}, 0, 1);
    sym(5'h00, 0, 0, 0, 4'h0, 0, 0);
    apb(1'b1, `PRX_OFF_CTRL, 32'h20);
    prx_line_model_i.tx(1'b1, 4'h3);
    // pins only move on a line edge, so give one while transmitting
    prx_line_model_i.put(5'h00, 1'b0, 1'b0, 1'b0);
    chk({pin.rxd, pin.col_crs_dv}, 5'h0);
    apb(1'b1, `PRX_OFF_CTRL, 32'h22);
    prx_line_model_i.put(5'h00, 1'b0, 1'b0, 1'b0);
    chk(pin.col_crs_dv, 1'b1);
    prx_line_model_i.tx(1'b0, 4'h0);
    $display("test reduced done");
  endtask : t_rmii

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial
  begin
    n_fail = 0;
    checks = 0;
    sys_rst = 1'b1;
    apb_req = '0;
    strap = '0;
    irq_req = 1'b0;
    irq_drv = 1'b1;
    t_straps(9'h15B);
    t_irq(1'b1);
    t_ctrl();
    t_mii();
    t_led();
    t_straps(9'h084);
    t_irq(1'b0);
    t_rmii();
    test_done();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #300000;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : prx_rx_status_test

bind prx_rx_status prx_rx_status_properties prx_rx_status_properties_i (
  .clk_sys, .sys_rst, .strap_pin_i, .pin_o, .pin_oe, .irq_out_n, .irq_pin_oe, .tx_err_o,
  .mgmt_addr, .op_mode, .rmii_mode, .regulator_disable, .straps_done);

`default_nettype wire
